// ---- dmnr_map.vh ----
// constants for the multiply, negate and round datapath
`ifndef DMNR_MAP_VH
`define DMNR_MAP_VH

// operation codes on op_i
`define DMNR_OP_MUL    3'h0
`define DMNR_OP_NEGD   3'h1
`define DMNR_OP_NEGA   3'h2
`define DMNR_OP_NEGAA  3'h3
`define DMNR_OP_RNDH   3'h4
`define DMNR_OP_RNDADD 3'h5
`define DMNR_OP_RNDSUB 3'h6
`define DMNR_OP_EXTR   3'h7

// data register limits
`define DMNR_D_MIN     32'h80000000
`define DMNR_D_MAX     32'h7FFFFFFF
`define DMNR_D_ZERO    32'h00000000

// accumulator limits
`define DMNR_A_MIN     40'h8000000000
`define DMNR_A_MAX     40'h7FFFFFFFFF
`define DMNR_A_ZERO    40'h0000000000

// half-word limits
`define DMNR_H_MAX     16'h7FFF
`define DMNR_H_MIN     16'h8000
`define DMNR_H_ZERO    16'h0000

// rounding positions: result lsb index
`define DMNR_RNDH_SH   16
`define DMNR_ROUND_AT_TWELVE_OPTION_SH  12

// write masks for the two register halves
`define DMNR_MASK_LO   2'h1
`define DMNR_MASK_HI   2'h2
`define DMNR_MASK_ALL  2'h3
`define DMNR_MASK_NONE 2'h0

`endif

// ---- dmnr_dregs.v ----
// eight data registers with half-word write mask and registered reads
`timescale 1ns/1ps
`include "dmnr_map.vh"
module dmnr_dregs (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // write port
  input  wire        we_i,
  input  wire [1:0]  wmask_i,
  input  wire [2:0]  waddr_i,
  input  wire [31:0] wdata_i,
  // read ports
  input  wire [2:0]  ra_i,
  input  wire [2:0]  rb_i,
  input  wire [2:0]  rc_i,
  output reg  [31:0] qa_o,
  output reg  [31:0] qb_o,
  output reg  [31:0] qc_o
);

  wire [255:0] flat_w;

  // one entry per register, each half written on its own mask bit
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_ent
      reg [31:0] ent_q;
      always @(posedge clk_i) begin
        if (rst_i) begin
          ent_q <= `DMNR_D_ZERO;
        end else if (we_i && (waddr_i == gi)) begin
          if (wmask_i[0]) ent_q[15:0] <= wdata_i[15:0];
          if (wmask_i[1]) ent_q[31:16] <= wdata_i[31:16];
        end
      end
      assign flat_w[gi*32 +: 32] = ent_q;
    end
  endgenerate

  // registered reads: data appear one edge after the address
  always @(posedge clk_i) begin
    if (rst_i) begin
      qa_o <= `DMNR_D_ZERO;
      qb_o <= `DMNR_D_ZERO;
      qc_o <= `DMNR_D_ZERO;
    end else begin
      qa_o <= flat_w[ra_i*32 +: 32];
      qb_o <= flat_w[rb_i*32 +: 32];
      qc_o <= flat_w[rc_i*32 +: 32];
    end
  end

endmodule

// ---- dmnr_rndsat.v ----
// biased round at a bit position, then 16-bit signed saturation
`timescale 1ns/1ps
`include "dmnr_map.vh"
module dmnr_rndsat #(
  parameter IW = 32,
  parameter SH = 16
) (
  input  wire [IW-1:0] in_i,
  output reg  [15:0]   res_o,
  output reg           sat_o
);

  localparam QW = IW + 1 - SH;

  wire [IW:0] half_w = {{IW{1'b0}}, 1'b1} << (SH - 1);
  wire [IW:0] sum_w  = {in_i[IW-1], in_i} + half_w;
  wire [QW-1:0] q_w  = sum_w[IW:SH];
  // all bits above the result sign must match it, else out of range
  wire fits_w = (q_w[QW-1:15] == {(QW-15){1'b0}}) ||
                (q_w[QW-1:15] == {(QW-15){1'b1}});

  // clamp toward the sign of the rounded sum
  always @* begin
    sat_o = ~fits_w;
    if (fits_w) begin
      res_o = q_w[15:0];
    end else if (sum_w[IW]) begin
      res_o = `DMNR_H_MIN;
    end else begin
      res_o = `DMNR_H_MAX;
    end
  end

endmodule

// ---- dmnr_alu.v ----
// multiply, negate and rounding datapath with status flags
`timescale 1ns/1ps
`include "dmnr_map.vh"

// Notes on behaviour
// RULE1: multiply keeps low 32 product bits
// RULE2: multiply never touches any status flag
// RULE3: multiply leaves accumulators alone, product overwrites source 0
// RULE4: multiply never pairs in a parallel group
// RULE5: negate is zero minus source, accumulators saturate
// RULE6: 0x80000000 negates to max only saturating
// RULE7: long form selects saturation, short never saturates
// RULE8: any accumulator pairing, or both together
// RULE9: zero and negative flags follow the result
// RULE10: data negate sets overflow, sticky only set
// RULE11: accumulator overflow per accumulator, sticky set
// RULE12: short negate never pairs in parallel
// RULE13: half-word round adds bit 15, keeps 31:16
// RULE14: rounding always biased, mode bit ignored
// RULE15: signed fraction source, any register half
// RULE16: add or subtract, round, keep bits 27:12
// RULE17: twelve-bit round adds bit 11 first
// RULE18: rounding overflow on saturation, sticky set
// RULE19: destination any of sixteen register halves
// RULE20: accumulator extract saturates to 32 bits
// RULE21: result and flags commit in one cycle
module dmnr_alu (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // operation request
  input  wire        op_valid_i,
  input  wire [2:0]  op_i,
  input  wire        op_short_i,
  input  wire        op_parallel_i,
  input  wire        op_sat_i,
  input  wire [2:0]  dst_i,
  input  wire        dst_hi_i,
  input  wire [2:0]  src0_i,
  input  wire [2:0]  src1_i,
  input  wire        acc_src_i,
  input  wire        acc_dst_i,
  // register loads from the core, idle cycles only
  input  wire        ld_dreg_en_i,
  input  wire [2:0]  ld_addr_i,
  input  wire [31:0] ld_data_i,
  input  wire        ld_acc0_en_i,
  input  wire        ld_acc1_en_i,
  input  wire [39:0] ld_acc_data_i,
  input  wire [2:0]  peek_addr_i,
  // operation status
  output reg         busy_o,
  output reg         done_o,
  output reg         refused_o,
  output reg  [31:0] result_o,
  // register views
  output wire [31:0] peek_data_o,
  output reg  [39:0] accumulator_zero_o,
  output reg  [39:0] accumulator_one_o,
  // arithmetic status flags
  output reg         zero_flag_o,
  output reg         negative_flag_o,
  output reg         overflow_flag_o,
  output reg         overflow_sticky_flag_o,
  output reg         acc0_overflow_flag_o,
  output reg         acc0_overflow_sticky_o,
  output reg         acc1_overflow_flag_o,
  output reg         acc1_overflow_sticky_o
);

  // captured operation, used in the execute cycle
  reg  [2:0] op_q;
  reg        short_q;
  reg        sat_q;
  reg  [2:0] dst_q;
  reg        hi_q;
  reg        asrc_q;
  reg        adst_q;

  wire [31:0] opa_w;
  wire [31:0] opb_w;

  // execute-cycle results
  reg         wr_d;
  reg  [1:0]  mask_d;
  reg  [31:0] wdata_d;
  reg  [31:0] res_d;
  reg  [39:0] acc0_d;
  reg  [39:0] acc1_d;
  reg         z_d;
  reg         n_d;
  reg         v_d;
  reg         vs_d;
  reg         av0_d;
  reg         acc0_overflow_sticky_d;
  reg         av1_d;
  reg         acc1_overflow_sticky_d;

  // negate of one accumulator: {saturated, value}
  function [40:0] neg_acc;
    input [39:0] a;
    begin
      if (a == `DMNR_A_MIN) begin
        neg_acc = {1'b1, `DMNR_A_MAX};
      end else begin
        neg_acc = {1'b0, `DMNR_A_ZERO - a};
      end
    end
  endfunction

  // any multiply or a short negate may not share an issue group
  wire bad_pair_w = op_parallel_i &&
                    ((op_i == `DMNR_OP_MUL) ||
                     ((op_i == `DMNR_OP_NEGD) && op_short_i));
  wire take_w = op_valid_i && !busy_o && !bad_pair_w;

  // register file: ports a/b feed operands, port c is the view
  dmnr_dregs u_dregs (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .we_i    (wr_d),
    .wmask_i (mask_d),
    .waddr_i (busy_o ? dst_q : ld_addr_i),
    .wdata_i (wdata_d),
    .ra_i    (src0_i),
    .rb_i    (src1_i),
    .rc_i    (peek_addr_i),
    .qa_o    (opa_w),
    .qb_o    (opb_w),
    .qc_o    (peek_data_o)
  );

  // rounding units; no mode input exists, so rounding is always biased
  wire [15:0] rh_w;
  wire        rh_sat_w;
  wire [15:0] r12_w;
  wire        r12_sat_w;
  wire        sub_w = (op_q == `DMNR_OP_RNDSUB);
  wire [32:0] ab_w  = sub_w ? ({opa_w[31], opa_w} - {opb_w[31], opb_w})
                            : ({opa_w[31], opa_w} + {opb_w[31], opb_w});

  // RULE13 half-word round
  dmnr_rndsat #(
    .IW (32),
    .SH (`DMNR_RNDH_SH)
  ) u_rndh (
    .in_i  (opa_w),
    .res_o (rh_w),
    .sat_o (rh_sat_w)
  );

  // RULE17 twelve-bit round
  dmnr_rndsat #(
    .IW (33),
    .SH (`DMNR_ROUND_AT_TWELVE_OPTION_SH)
  ) u_round_at_twelve_option (
    .in_i  (ab_w),
    .res_o (r12_w),
    .sat_o (r12_sat_w)
  );

  wire [63:0] prod_w = opa_w * opb_w;
  wire [39:0] asel_w = asrc_q ? accumulator_one_o : accumulator_zero_o;
  wire [40:0] nsel_w = neg_acc(asel_w);
  wire [40:0] n0_w   = neg_acc(accumulator_zero_o);
  wire [40:0] n1_w   = neg_acc(accumulator_one_o);
  wire [15:0] r16_w  = (op_q == `DMNR_OP_RNDH) ? rh_w : r12_w;
  wire        rsat_w = (op_q == `DMNR_OP_RNDH) ? rh_sat_w : r12_sat_w;
  wire        ovr_w  = (opa_w == `DMNR_D_MIN);

  // compute result, write enable and next flags for this cycle
  always @* begin
    wr_d    = 1'b0;
    mask_d  = `DMNR_MASK_NONE;
    wdata_d = ld_data_i;
    res_d   = result_o;
    acc0_d  = accumulator_zero_o;
    acc1_d  = accumulator_one_o;
    z_d     = zero_flag_o;
    n_d     = negative_flag_o;
    v_d     = overflow_flag_o;
    vs_d    = overflow_sticky_flag_o;
    av0_d   = acc0_overflow_flag_o;
    acc0_overflow_sticky_d  = acc0_overflow_sticky_o;
    av1_d   = acc1_overflow_flag_o;
    acc1_overflow_sticky_d  = acc1_overflow_sticky_o;
    if (!busy_o) begin
      // idle: core loads are applied, flags hold
      wr_d   = ld_dreg_en_i;
      mask_d = `DMNR_MASK_ALL;
      if (ld_acc0_en_i) acc0_d = ld_acc_data_i;
      if (ld_acc1_en_i) acc1_d = ld_acc_data_i;
    end else begin
      case (op_q)
        `DMNR_OP_MUL: begin
          // RULE1 low word only
          wr_d    = 1'b1;
          mask_d  = `DMNR_MASK_ALL;
          wdata_d = prod_w[31:0];
          res_d   = prod_w[31:0];
          // RULE2 no flag assignment on this path
          // RULE3 accumulators keep their defaults
        end
        `DMNR_OP_NEGD: begin
          wr_d   = 1'b1;
          mask_d = `DMNR_MASK_ALL;
          // RULE6 only the most negative input can overflow
          // RULE7 short form ignores the saturation select
          if (ovr_w && sat_q && !short_q) begin
            wdata_d = `DMNR_D_MAX;
          end else begin
            wdata_d = `DMNR_D_ZERO - opa_w;
          end
          res_d = wdata_d;
          // RULE9 flags from result
          z_d = (wdata_d == `DMNR_D_ZERO);
          n_d = wdata_d[31];
          // RULE10 overflow set or cleared, sticky only set
          v_d  = ovr_w;
          vs_d = overflow_sticky_flag_o | ovr_w;
        end
        `DMNR_OP_NEGA: begin
          // RULE8 any source to any destination
          // RULE5 zero minus source, saturated at 40 bits
          if (adst_q) begin
            acc1_d = nsel_w[39:0];
            // RULE11 per-accumulator overflow
            av1_d  = nsel_w[40];
            acc1_overflow_sticky_d = acc1_overflow_sticky_o | nsel_w[40];
          end else begin
            acc0_d = nsel_w[39:0];
            av0_d  = nsel_w[40];
            acc0_overflow_sticky_d = acc0_overflow_sticky_o | nsel_w[40];
          end
          res_d = nsel_w[31:0];
          z_d   = (nsel_w[39:0] == `DMNR_A_ZERO);
          n_d   = nsel_w[39];
        end
        `DMNR_OP_NEGAA: begin
          // RULE8 both accumulators at once
          acc0_d = n0_w[39:0];
          acc1_d = n1_w[39:0];
          // RULE11 each accumulator judged on its own
          av0_d  = n0_w[40];
          acc0_overflow_sticky_d = acc0_overflow_sticky_o | n0_w[40];
          av1_d  = n1_w[40];
          acc1_overflow_sticky_d = acc1_overflow_sticky_o | n1_w[40];
          res_d  = n0_w[31:0];
          // RULE9 two results combine by or
          z_d = (n0_w[39:0] == `DMNR_A_ZERO) | (n1_w[39:0] == `DMNR_A_ZERO);
          n_d = n0_w[39] | n1_w[39];
        end
        `DMNR_OP_RNDH,
        `DMNR_OP_RNDADD,
        `DMNR_OP_RNDSUB: begin
          // RULE19 half picked by the destination select
          // RULE15 result lands in one half only
          wr_d    = 1'b1;
          mask_d  = hi_q ? `DMNR_MASK_HI : `DMNR_MASK_LO;
          wdata_d = {r16_w, r16_w};
          res_d   = {`DMNR_H_ZERO, r16_w};
          // RULE16 add or subtract before rounding
          // RULE14 no mode input consulted
          z_d = (r16_w == `DMNR_H_ZERO);
          n_d = r16_w[15];
          // RULE18 overflow follows saturation
          v_d  = rsat_w;
          vs_d = overflow_sticky_flag_o | rsat_w;
        end
        `DMNR_OP_EXTR: begin
          // RULE20 clamp accumulator to 32-bit range
          wr_d   = 1'b1;
          mask_d = `DMNR_MASK_ALL;
          if ((asel_w[39:31] == 9'h000) || (asel_w[39:31] == 9'h1FF)) begin
            wdata_d = asel_w[31:0];
          end else if (asel_w[39]) begin
            wdata_d = `DMNR_D_MIN;
          end else begin
            wdata_d = `DMNR_D_MAX;
          end
          res_d = wdata_d;
        end
        default: begin
          wr_d = 1'b0;
        end
      endcase
    end
  end

  // RULE4 RULE12 refusal of forbidden parallel groups
  always @(posedge clk_i) begin
    if (rst_i) begin
      refused_o <= 1'b0;
    end else begin
      refused_o <= op_valid_i && !busy_o && bad_pair_w;
    end
  end

  // capture an accepted operation; operands read at the same edge
  always @(posedge clk_i) begin
    if (rst_i) begin
      busy_o  <= 1'b0;
      done_o  <= 1'b0;
      op_q    <= `DMNR_OP_MUL;
      short_q <= 1'b0;
      sat_q   <= 1'b0;
      dst_q   <= 3'h0;
      hi_q    <= 1'b0;
      asrc_q  <= 1'b0;
      adst_q  <= 1'b0;
    end else begin
      // one operation in flight keeps reads clear of pending writes
      busy_o <= take_w;
      done_o <= busy_o;
      if (take_w) begin
        op_q    <= op_i;
        short_q <= op_short_i;
        sat_q   <= op_sat_i;
        dst_q   <= (op_i == `DMNR_OP_MUL) ? src0_i : dst_i;
        hi_q    <= dst_hi_i;
        asrc_q  <= acc_src_i;
        adst_q  <= acc_dst_i;
      end
    end
  end

  // RULE21 result, accumulators and flags commit on one edge
  always @(posedge clk_i) begin
    if (rst_i) begin
      result_o               <= `DMNR_D_ZERO;
      accumulator_zero_o     <= `DMNR_A_ZERO;
      accumulator_one_o      <= `DMNR_A_ZERO;
      zero_flag_o            <= 1'b0;
      negative_flag_o        <= 1'b0;
      overflow_flag_o        <= 1'b0;
      overflow_sticky_flag_o <= 1'b0;
      acc0_overflow_flag_o   <= 1'b0;
      acc0_overflow_sticky_o <= 1'b0;
      acc1_overflow_flag_o   <= 1'b0;
      acc1_overflow_sticky_o <= 1'b0;
    end else begin
      result_o               <= res_d;
      accumulator_zero_o     <= acc0_d;
      accumulator_one_o      <= acc1_d;
      zero_flag_o            <= z_d;
      negative_flag_o        <= n_d;
      overflow_flag_o        <= v_d;
      overflow_sticky_flag_o <= vs_d;
      acc0_overflow_flag_o   <= av0_d;
      acc0_overflow_sticky_o <= acc0_overflow_sticky_d;
      acc1_overflow_flag_o   <= av1_d;
      acc1_overflow_sticky_o <= acc1_overflow_sticky_d;
    end
  end

endmodule

// ---- dmnr_alu_properties.sv ----
// port assertions for the multiply, negate and round datapath
`timescale 1ns/1ps
module dmnr_alu_properties (
  // clock and reset
  input logic        clk_i,
  input logic        rst_i,
  // request
  input logic        op_valid_i,
  input logic [2:0]  op_i,
  input logic        op_short_i,
  input logic        op_parallel_i,
  // answer
  input logic        busy_o,
  input logic        done_o,
  input logic        refused_o,
  input logic [31:0] result_o,
  // flags
  input logic        zero_flag_o,
  input logic        negative_flag_o,
  input logic        overflow_flag_o,
  input logic        overflow_sticky_flag_o,
  input logic        acc0_overflow_flag_o,
  input logic        acc0_overflow_sticky_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // a parallel multiply or short negate is refused, not executed
  wire       bad  = op_parallel_i && (op_i == 3'h0 || (op_i == 3'h1 && op_short_i));
  wire       take = op_valid_i && !busy_o && !bad;
  wire [5:0] flg  = {zero_flag_o, negative_flag_o, overflow_flag_o,
                     overflow_sticky_flag_o, acc0_overflow_flag_o, acc0_overflow_sticky_o};
  // answer shape and which kind of operation just completed
  sequence s_ans;
    busy_o ##1 done_o ##1 !done_o;
  endsequence
  sequence s_neg;
    done_o && $past(op_i, 2) == 3'h1;
  endsequence
  sequence s_rnd;
    done_o && $past(op_i, 2) inside {3'h4, 3'h5, 3'h6};
  endsequence
  AST_ANSWER:
    assert property (take |=> s_ans) else $error("no answer after accept");
  AST_REFUSE:
    assert property (op_valid_i && !busy_o && bad |=> refused_o && !busy_o ##1 !done_o)
      else $error("forbidden parallel request not refused");
  // flags commit on the same edge that raises done, so compare there
  AST_MUL_FLAGS:
    assert property (take && op_i == 3'h0 |-> ##2 $stable(flg)) else $error("multiply moved a flag");
  AST_NEG_FLAGS:
    assert property (s_neg |-> zero_flag_o == (result_o == 32'h0) && negative_flag_o == result_o[31])
      else $error("negate zero or negative flag wrong");
  AST_RND_FLAGS:
    assert property (s_rnd |-> zero_flag_o == (result_o[15:0] == 16'h0)
      && negative_flag_o == result_o[15]) else $error("round zero or negative flag wrong");
  AST_RND_SAT:
    assert property (s_rnd ##0 overflow_flag_o |-> result_o[15:0] inside {16'h7FFF, 16'h8000})
      else $error("round overflow without a limit value");
  AST_STICKY_SET:
    assert property (overflow_flag_o |-> overflow_sticky_flag_o) else $error("sticky not set");
  AST_STICKY_HOLD:
    assert property (overflow_sticky_flag_o |=> overflow_sticky_flag_o)
      else $error("sticky flag cleared");
  AST_ACC_STICKY:
    assert property (acc0_overflow_flag_o |-> acc0_overflow_sticky_o)
      else $error("accumulator sticky not set");
endmodule

// ---- dmnr_core_model.sv ----
// core side model: register file loads between operations
`timescale 1ns/1ps
module dmnr_core_model (
  // clock
  input  wire logic   clk_i,
  // data register load
  output logic        dreg_en_o,
  output logic [2:0]  dreg_addr_o,
  output logic [31:0] dreg_data_o,
  // accumulator load
  output logic [1:0]  acc_en_o,
  output logic [39:0] acc_data_o
);
  // idle at time zero
  initial begin
    dreg_en_o = 1'b0;
    dreg_addr_o = 3'h0;
    dreg_data_o = 32'h0;
    acc_en_o = 2'h0;
    acc_data_o = 40'h0;
  end
  // one-cycle load; data inverted after so a stale value never looks valid
  task automatic load_d(input logic [2:0] a, input logic [31:0] x);
    @(posedge clk_i);
    #1;
    dreg_en_o = 1'b1;
    dreg_addr_o = a;
    dreg_data_o = x;
    @(posedge clk_i);
    #1;
    dreg_en_o = 1'b0;
    dreg_data_o = ~x;
  endtask
  task automatic load_a(input logic [1:0] e, input logic [39:0] x);
    @(posedge clk_i);
    #1;
    acc_en_o = e;
    acc_data_o = x;
    @(posedge clk_i);
    #1;
    acc_en_o = 2'h0;
    acc_data_o = ~x;
  endtask
endmodule

// ---- tb.sv ----
// self-checking bench for the multiply, negate and round datapath
`timescale 1ns/1ps
`define CK(g, w) begin samples_checked++; if ((g) !== (w)) begin miscompares++; \
  $display("ERROR %0t got %h want %h", $time, g, w); end end
module tb;
  // stimulus and observed values
  logic        clk_i;
  logic        rst_i;
  logic        v;
  logic [2:0]  c;
  logic [3:0]  m;
  logic [2:0]  d;
  logic [2:0]  s0;
  logic [2:0]  s1;
  logic [2:0]  pa;
  logic        busy;
  logic        done;
  logic        refd;
  logic [31:0] res;
  logic [31:0] pk;
  logic [31:0] q;
  logic [39:0] acz;
  logic [39:0] aco;
  wire  [7:0]  f;
  logic        lde;
  logic [2:0]  lda;
  logic [31:0] ldd;
  logic [1:0]  lae;
  logic [39:0] lad;
  logic [31:0] p = 32'h12345678 * 32'h9ABCDEF1;
  int          miscompares = 0;
  int          samples_checked = 0;
  // core side loads
  dmnr_core_model u_core (
    .clk_i(clk_i), .dreg_en_o(lde), .dreg_addr_o(lda), .dreg_data_o(ldd),
    .acc_en_o(lae), .acc_data_o(lad)
  );
  // mode bits are {short, parallel, saturate, high half}
  dmnr_alu u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .op_valid_i(v), .op_i(c), .op_short_i(m[3]),
    .op_parallel_i(m[2]), .op_sat_i(m[1]), .dst_hi_i(m[0]), .dst_i(d), .src0_i(s0),
    .src1_i(s1), .acc_src_i(s0[0]), .acc_dst_i(d[0]), .ld_dreg_en_i(lde),
    .ld_addr_i(lda), .ld_data_i(ldd), .ld_acc0_en_i(lae[0]), .ld_acc1_en_i(lae[1]),
    .ld_acc_data_i(lad), .peek_addr_i(pa), .busy_o(busy), .done_o(done),
    .refused_o(refd), .result_o(res), .peek_data_o(pk), .accumulator_zero_o(acz),
    .accumulator_one_o(aco), .zero_flag_o(f[7]), .negative_flag_o(f[6]),
    .overflow_flag_o(f[5]), .overflow_sticky_flag_o(f[4]), .acc0_overflow_flag_o(f[3]),
    .acc0_overflow_sticky_o(f[2]), .acc1_overflow_flag_o(f[1]), .acc1_overflow_sticky_o(f[0])
  );
  // 250 MHz core clock
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // verdict and end of run
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // one request edge, then a bounded wait for done or refusal
  task automatic go(input logic [2:0] oc, input logic [3:0] mm, input logic [2:0] dd,
                    input logic [2:0] aa, input logic [2:0] bb);
    int n;
    @(posedge clk_i);
    #1;
    v = 1'b1;
    c = oc;
    m = mm;
    d = dd;
    s0 = aa;
    s1 = bb;
    @(posedge clk_i);
    #1;
    v = 1'b0;
    c = ~oc;
    n = 0;
    while (done !== 1'b1 && refd !== 1'b1) begin
      if (n == 8) begin
        miscompares++;
        tally_and_finish;
      end
      @(posedge clk_i);
      #1;
      n++;
    end
  endtask
  // operation with expected result and {zero, negative, overflow, sticky}
  task automatic ex(input logic [2:0] oc, input logic [3:0] mm, input logic [2:0] dd,
                    input logic [2:0] aa, input logic [2:0] bb, input logic [31:0] r,
                    input logic [3:0] fl);
    go(oc, mm, dd, aa, bb);
    `CK(res, r);
    `CK(f[7:4], fl);
  endtask
  // registered view of one data register
  task automatic rd(input logic [2:0] a);
    pa = a;
    @(posedge clk_i);
    #1;
    q = pk;
  endtask
  // main sequence
  initial begin
    rst_i = 1'b1;
    v = 1'b0;
    c = 3'h0;
    m = 4'h0;
    d = 3'h0;
    s0 = 3'h0;
    s1 = 3'h0;
    pa = 3'h0;
    repeat (8) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    `CK({f, acz, aco}, 88'h0);
    u_core.load_d(3'h0, 32'h80000000);
    ex(3'h1, 4'h2, 3'h3, 3'h0, 3'h0, 32'h7FFFFFFF, 4'h3);
    ex(3'h1, 4'h0, 3'h4, 3'h0, 3'h0, 32'h80000000, 4'h7);
    ex(3'h1, 4'hA, 3'h5, 3'h0, 3'h0, 32'h80000000, 4'h7);
    ex(3'h1, 4'h2, 3'h6, 3'h3, 3'h0, 32'h80000001, 4'h5);
    ex(3'h1, 4'h0, 3'h7, 3'h7, 3'h0, 32'h00000000, 4'h9);
    rd(3'h5);
    `CK(q, 32'h80000000);
    $display("test negate done");
    u_core.load_a(2'h1, 40'h8000000000);
    u_core.load_a(2'h2, 40'h0000000001);
    ex(3'h2, 4'h0, 3'h0, 3'h0, 3'h0, 32'hFFFFFFFF, 4'h1);
    `CK({acz, f[3:2]}, {40'h7FFFFFFFFF, 2'h3});
    ex(3'h2, 4'h0, 3'h0, 3'h1, 3'h0, 32'hFFFFFFFF, 4'h5);
    `CK({acz, f[3:2]}, {40'hFFFFFFFFFF, 2'h1});
    go(3'h3, 4'h0, 3'h0, 3'h0, 3'h0);
    `CK({acz, aco, f[7:6]}, {40'h1, 40'hFFFFFFFFFF, 2'h1});
    $display("test accumulator done");
    u_core.load_d(3'h1, 32'h12345678);
    u_core.load_d(3'h2, 32'h9ABCDEF1);
    go(3'h0, 4'h0, 3'h0, 3'h1, 3'h2);
    `CK(f, 8'h54);
    `CK({acz, aco}, {40'h1, 40'hFFFFFFFFFF});
    rd(3'h1);
    `CK(q, p);
    rd(3'h2);
    `CK(q, 32'h9ABCDEF1);
    go(3'h0, 4'h4, 3'h0, 3'h1, 3'h2);
    `CK(refd, 1'b1);
    rd(3'h1);
    `CK(q, p);
    go(3'h1, 4'hC, 3'h6, 3'h0, 3'h0);
    `CK(refd, 1'b1);
    rd(3'h6);
    `CK(q, 32'h80000001);
    ex(3'h1, 4'h6, 3'h6, 3'h0, 3'h0, 32'h7FFFFFFF, 4'h3);
    $display("test multiply done");
    u_core.load_d(3'h6, 32'hFFFCFFFF);
    u_core.load_d(3'h7, 32'h00018000);
    ex(3'h4, 4'h0, 3'h1, 3'h6, 3'h0, 32'h0000FFFD, 4'h5);
    ex(3'h4, 4'h1, 3'h1, 3'h7, 3'h0, 32'h00000002, 4'h1);
    rd(3'h1);
    `CK(q, 32'h0002FFFD);
    ex(3'h4, 4'h0, 3'h0, 3'h3, 3'h0, 32'h00007FFF, 4'h3);
    ex(3'h5, 4'h0, 3'h2, 3'h6, 3'h7, 32'h0000FFE8, 4'h5);
    ex(3'h6, 4'h1, 3'h2, 3'h6, 3'h7, 32'h0000FFB8, 4'h5);
    rd(3'h2);
    `CK(q, 32'hFFB8FFE8);
    u_core.load_d(3'h5, 32'h00000800);
    ex(3'h5, 4'h0, 3'h3, 3'h5, 3'h7, 32'h00000019, 4'h1);
    u_core.load_d(3'h5, 32'h000007FF);
    ex(3'h5, 4'h0, 3'h3, 3'h5, 3'h7, 32'h00000018, 4'h1);
    u_core.load_d(3'h4, 32'h08000000);
    u_core.load_d(3'h5, 32'h18000000);
    ex(3'h5, 4'h0, 3'h3, 3'h4, 3'h4, 32'h00007FFF, 4'h3);
    ex(3'h6, 4'h0, 3'h3, 3'h4, 3'h5, 32'h00008000, 4'h7);
    $display("test round done");
    // accumulator one saturates, then extracts clamp or pass through
    u_core.load_a(2'h1, 40'h8000000000);
    ex(3'h2, 4'h0, 3'h1, 3'h0, 3'h0, 32'hFFFFFFFF, 4'h3);
    `CK({aco, f[1:0]}, {40'h7FFFFFFFFF, 2'h3});
    ex(3'h7, 4'h0, 3'h0, 3'h1, 3'h0, 32'h7FFFFFFF, 4'h3);
    ex(3'h7, 4'h0, 3'h1, 3'h0, 3'h0, 32'h80000000, 4'h3);
    u_core.load_a(2'h1, 40'hFFFFFFFFFE);
    ex(3'h7, 4'h0, 3'h2, 3'h0, 3'h0, 32'hFFFFFFFE, 4'h3);
    rd(3'h1);
    `CK(q, 32'h80000000);
    $display("test extract done");
    tally_and_finish;
  end
endmodule
// checker beside the datapath ports
bind dmnr_alu dmnr_alu_properties u_props (
  .clk_i(clk_i), .rst_i(rst_i), .op_valid_i(op_valid_i), .op_i(op_i),
  .op_short_i(op_short_i), .op_parallel_i(op_parallel_i), .busy_o(busy_o),
  .done_o(done_o), .refused_o(refused_o), .result_o(result_o),
  .zero_flag_o(zero_flag_o), .negative_flag_o(negative_flag_o),
  .overflow_flag_o(overflow_flag_o), .overflow_sticky_flag_o(overflow_sticky_flag_o),
  .acc0_overflow_flag_o(acc0_overflow_flag_o), .acc0_overflow_sticky_o(acc0_overflow_sticky_o)
);
